// file: core/ots_pkg.sv
// constants shared by the terminal status word exchange design
// assumes a single 100 MHz clock and a word-wide request port towards the host controller
package ots_pkg;

   localparam int          CLK_NS          = 10;
   localparam int          POLL_NS         = 1000;
   localparam int          POLL_CYC        = (POLL_NS + CLK_NS - 1) / CLK_NS;

   localparam int          CTL_WORDS       = 4;
   localparam logic [1:0]  CTL_SCREEN_OFS  = 2'h0;
   localparam logic [1:0]  CTL_COPY_SRC_OFS = 2'h1;
   localparam logic [1:0]  CTL_COPY_DST_OFS = 2'h2;
   localparam logic [1:0]  CTL_BITS_OFS    = 2'h3;

   localparam int          NTF_WORDS       = 3;
   localparam logic [1:0]  NTF_SCREEN_OFS  = 2'h0;
   localparam logic [1:0]  NTF_TABLE_OFS   = 2'h1;
   localparam logic [1:0]  NTF_STATUS_OFS  = 2'h2;

   localparam int          CTL_BACKLIGHT_BIT = 15;
   localparam int          CTL_BUZZER_BIT    = 14;
   localparam int          CTL_PRIORITY_BIT  = 13;
   localparam int          COPY_TYPE_LSB     = 12;
   localparam logic [3:0]  COPY_TYPE_STRING  = 4'h0;
   localparam logic [3:0]  COPY_TYPE_NUMERAL = 4'h1;

   localparam int          NTF_RUN_BIT       = 15;
   localparam int          NTF_SCR_STB_BIT   = 14;
   localparam int          NTF_NUM_STB_BIT   = 13;
   localparam int          NTF_PRIO_BIT      = 12;

   localparam logic [4:0]  NUM_WORDS_MAX   = 5'h02;
   localparam logic [4:0]  STR_WORDS_MAX   = 5'h10;
   localparam logic [15:0] SCREEN_CLEAR    = 16'h0000;
   localparam logic [15:0] WORD_RST        = 16'h0000;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_CTRL,
      ST_APPLY,
      ST_NOTIFY,
      ST_ELEM,
      ST_EVENT
   } ots_state_type;

endpackage

// file: core/ots_flag.sv
// sticky pending flag in which a set wins over a clear in the same cycle
// assumes set and clear are synchronous one-cycle pulses
`timescale 1ns/1ns
`default_nettype none
module ots_flag
(
   input  wire logic ref_clk_i,
   input  wire logic rst_b_i,
   input  wire logic set_i,
   input  wire logic clr_i,
   output var  logic flag_o
);
   import ots_pkg::*;

   typedef struct packed {
      logic flag;
   } ots_flag_type;

   ots_flag_type s_q;
   ots_flag_type s_d;

   always_comb
   begin
      s_d      = s_q;
      s_d.flag = set_i | (s_q.flag & ~clr_i);
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign flag_o = s_q.flag;
endmodule
`default_nettype wire

// file: core/ots_ctrl_decode.sv
// decodes a freshly read control area against the copy held from the previous poll
// assumes both copies are stable registered words
`timescale 1ns/1ns
`default_nettype none
module ots_ctrl_decode
(
   input  wire logic [ots_pkg::CTL_WORDS-1:0][15:0] new_i,
   input  wire logic [ots_pkg::CTL_WORDS-1:0][15:0] old_i,
   input  wire logic                                one_to_many_i,
   output var  logic                                screen_switch_o,
   output var  logic                                copy_fire_o,
   output var  logic [11:0]                         copy_src_o,
   output var  logic [11:0]                         copy_dst_o,
   output var  logic [3:0]                          copy_type_o,
   output var  logic                                buzzer_o,
   output var  logic                                backlight_o,
   output var  logic                                priority_o
);
   import ots_pkg::*;

   always_comb
   begin
      // only a changed, nonzero number switches; zero clears the request
      screen_switch_o = (new_i[CTL_SCREEN_OFS] != old_i[CTL_SCREEN_OFS]) &&
                        (new_i[CTL_SCREEN_OFS] != SCREEN_CLEAR);
      copy_fire_o     = (new_i[CTL_COPY_SRC_OFS] != old_i[CTL_COPY_SRC_OFS]) ||
                        (new_i[CTL_COPY_DST_OFS] != old_i[CTL_COPY_DST_OFS]);
      copy_src_o      = new_i[CTL_COPY_SRC_OFS][11:0];
      copy_dst_o      = new_i[CTL_COPY_DST_OFS][11:0];
      copy_type_o     = new_i[CTL_COPY_DST_OFS][COPY_TYPE_LSB +: 4];
      buzzer_o        = new_i[CTL_BITS_OFS][CTL_BUZZER_BIT];
      backlight_o     = new_i[CTL_BITS_OFS][CTL_BACKLIGHT_BIT];
      priority_o      = new_i[CTL_BITS_OFS][CTL_PRIORITY_BIT] & one_to_many_i;
   end
endmodule
`default_nettype wire

// file: core/ots_exchange.sv
// operator terminal side of the status word exchange with the host controller
// assumes the link is abstracted to one word request at a time, answered by a one-cycle acknowledge
`timescale 1ns/1ns
`default_nettype none
module ots_exchange
#(
   parameter int NUM_ELEM = 4
)
(
   input  wire logic                   ref_clk_i,
   input  wire logic                   rst_b_i,
   input  wire logic [15:0]            ctl_base_i,
   input  wire logic [15:0]            ntf_base_i,
   input  wire logic                   one_to_many_i,
   input  wire logic                   op_status_i,
   input  wire logic [NUM_ELEM*16-1:0] elem_addr_i,
   output var  logic [NUM_ELEM*16-1:0] elem_value_o,
   input  wire logic                   ev_valid_i,
   input  wire logic [15:0]            ev_addr_i,
   input  wire logic [4:0]             ev_len_i,
   input  wire logic                   ev_numeral_i,
   input  wire logic [11:0]            ev_table_i,
   input  wire logic [255:0]           ev_data_i,
   output var  logic                   ev_busy_o,
   output var  logic                   ev_reject_o,
   output var  logic                   req_valid_o,
   output var  logic                   req_write_o,
   output var  logic [15:0]            req_addr_o,
   output var  logic [15:0]            req_wdata_o,
   input  wire logic                   host_ack_i,
   input  wire logic [15:0]            host_rdata_i,
   output var  logic [15:0]            screen_o,
   output var  logic                   buzzer_o,
   output var  logic                   backlight_o,
   output var  logic                   priority_reg_o,
   output var  logic                   copy_req_o,
   output var  logic [11:0]            copy_src_o,
   output var  logic [11:0]            copy_dst_o,
   output var  logic [3:0]             copy_type_o
);
   import ots_pkg::*;

   typedef struct packed {
      ots_state_type                  st;
      logic [15:0]                    cnt;
      logic [4:0]                     idx;
      logic                           req_valid;
      logic                           req_write;
      logic [15:0]                    req_addr;
      logic [15:0]                    req_wdata;
      logic [CTL_WORDS-1:0][15:0]     shadow;
      logic [CTL_WORDS-1:0][15:0]     ctl;
      logic [15:0]                    screen;
      logic                           buzzer;
      logic                           backlight;
      logic                           prio;
      logic                           copy_req;
      logic [11:0]                    copy_src;
      logic [11:0]                    copy_dst;
      logic [3:0]                     copy_type;
      logic [NUM_ELEM-1:0][15:0]      elem_val;
      logic                           ev_hold;
      logic [15:0]                    ev_addr;
      logic [4:0]                     ev_len;
      logic                           ev_numeral;
      logic [11:0]                    ev_table;
      logic [15:0][15:0]              ev_data;
      logic                           ev_reject;
      logic [11:0]                    num_table;
   } ots_exch_type;

   ots_exch_type s_q;
   ots_exch_type s_d;

   logic        ack;
   logic        dec_switch;
   logic        dec_copy;
   logic [11:0] dec_src;
   logic [11:0] dec_dst;
   logic [3:0]  dec_type;
   logic        dec_buzzer;
   logic        dec_backlight;
   logic        dec_prio;
   logic        scr_word_set;
   logic        scr_word_clr;
   logic        scr_stb_set;
   logic        scr_stb_clr;
   logic        num_word_set;
   logic        num_word_clr;
   logic        num_stb_set;
   logic        num_stb_clr;
   logic        scr_word_pend;
   logic        scr_stb_pend;
   logic        num_word_pend;
   logic        num_stb_pend;
   logic [15:0] status_word;
   logic [4:0]  ev_limit;

   assign ack = host_ack_i & s_q.req_valid;

   ots_ctrl_decode u_decode
   (
      .new_i           (s_q.shadow),
      .old_i           (s_q.ctl),
      .one_to_many_i   (one_to_many_i),
      .screen_switch_o (dec_switch),
      .copy_fire_o     (dec_copy),
      .copy_src_o      (dec_src),
      .copy_dst_o      (dec_dst),
      .copy_type_o     (dec_type),
      .buzzer_o        (dec_buzzer),
      .backlight_o     (dec_backlight),
      .priority_o      (dec_prio)
   );

   ots_flag u_scr_word
   (
      .ref_clk_i (ref_clk_i),
      .rst_b_i   (rst_b_i),
      .set_i     (scr_word_set),
      .clr_i     (scr_word_clr),
      .flag_o    (scr_word_pend)
   );

   ots_flag u_scr_stb
   (
      .ref_clk_i (ref_clk_i),
      .rst_b_i   (rst_b_i),
      .set_i     (scr_stb_set),
      .clr_i     (scr_stb_clr),
      .flag_o    (scr_stb_pend)
   );

   ots_flag u_num_word
   (
      .ref_clk_i (ref_clk_i),
      .rst_b_i   (rst_b_i),
      .set_i     (num_word_set),
      .clr_i     (num_word_clr),
      .flag_o    (num_word_pend)
   );

   ots_flag u_num_stb
   (
      .ref_clk_i (ref_clk_i),
      .rst_b_i   (rst_b_i),
      .set_i     (num_stb_set),
      .clr_i     (num_stb_clr),
      .flag_o    (num_stb_pend)
   );

   always_comb
   begin
      // a strobe is only shown once its companion word has reached the host
      status_word                  = WORD_RST;
      status_word[NTF_RUN_BIT]     = op_status_i;
      status_word[NTF_SCR_STB_BIT] = scr_stb_pend & ~scr_word_pend;
      status_word[NTF_NUM_STB_BIT] = num_stb_pend & ~num_word_pend;
      status_word[NTF_PRIO_BIT]    = s_q.prio;
   end

   always_comb
   begin
      s_d          = s_q;
      s_d.copy_req = 1'b0;
      s_d.ev_reject = 1'b0;
      scr_word_set = 1'b0;
      scr_word_clr = 1'b0;
      scr_stb_set  = 1'b0;
      scr_stb_clr  = 1'b0;
      num_word_set = 1'b0;
      num_word_clr = 1'b0;
      num_stb_set  = 1'b0;
      num_stb_clr  = 1'b0;
      ev_limit     = ev_numeral_i ? NUM_WORDS_MAX : STR_WORDS_MAX;
      if (ack)
      begin
         s_d.req_valid = 1'b0;
      end
      case (s_q.st)
         ST_IDLE:
         begin
            if (s_q.cnt == 16'h0000)
            begin
               s_d.st  = ST_CTRL;
               s_d.idx = 5'h00;
            end
            else
            begin
               s_d.cnt = s_q.cnt - 16'h0001;
            end
         end
         ST_CTRL:
         begin
            if (!s_q.req_valid)
            begin
               s_d.req_valid = 1'b1;
               s_d.req_write = 1'b0;
               s_d.req_addr  = ctl_base_i + {14'h0000, s_q.idx[1:0]};
            end
            else if (ack)
            begin
               s_d.shadow[s_q.idx[1:0]] = host_rdata_i;
               if (s_q.idx[1:0] == CTL_BITS_OFS)
                  s_d.st = ST_APPLY;
               else
                  s_d.idx = s_q.idx + 5'h01;
            end
         end
         ST_APPLY:
         begin
            if (dec_switch)
            begin
               s_d.screen   = s_q.shadow[CTL_SCREEN_OFS];
               scr_word_set = 1'b1;
               scr_stb_set  = 1'b1;
            end
            if (dec_copy)
            begin
               s_d.copy_req  = 1'b1;
               s_d.copy_src  = dec_src;
               s_d.copy_dst  = dec_dst;
               s_d.copy_type = dec_type;
            end
            s_d.buzzer    = dec_buzzer;
            s_d.backlight = dec_backlight;
            s_d.prio      = dec_prio;
            s_d.ctl       = s_q.shadow;
            s_d.st        = ST_NOTIFY;
            s_d.idx       = 5'h00;
         end
         ST_NOTIFY:
         begin
            if (!s_q.req_valid)
            begin
               if (s_q.idx[1:0] == NTF_SCREEN_OFS && !scr_word_pend)
                  s_d.idx = s_q.idx + 5'h01;
               else if (s_q.idx[1:0] == NTF_TABLE_OFS && !num_word_pend)
                  s_d.idx = s_q.idx + 5'h01;
               else
               begin
                  s_d.req_valid = 1'b1;
                  s_d.req_write = 1'b1;
                  s_d.req_addr  = ntf_base_i + {14'h0000, s_q.idx[1:0]};
                  if (s_q.idx[1:0] == NTF_SCREEN_OFS)
                     s_d.req_wdata = s_q.screen;
                  else if (s_q.idx[1:0] == NTF_TABLE_OFS)
                     s_d.req_wdata = {4'h0, s_q.num_table};
                  else
                     s_d.req_wdata = status_word;
               end
            end
            else if (ack)
            begin
               if (s_q.idx[1:0] == NTF_SCREEN_OFS)
                  scr_word_clr = 1'b1;
               else if (s_q.idx[1:0] == NTF_TABLE_OFS)
                  num_word_clr = 1'b1;
               else
               begin
                  // a strobe that reached the host falls back on the next round
                  scr_stb_clr = s_q.req_wdata[NTF_SCR_STB_BIT];
                  num_stb_clr = s_q.req_wdata[NTF_NUM_STB_BIT];
               end
               if (s_q.idx[1:0] == NTF_STATUS_OFS)
               begin
                  s_d.st  = ST_ELEM;
                  s_d.idx = 5'h00;
               end
               else
                  s_d.idx = s_q.idx + 5'h01;
            end
         end
         ST_ELEM:
         begin
            if (!s_q.req_valid)
            begin
               s_d.req_valid = 1'b1;
               s_d.req_write = 1'b0;
               s_d.req_addr  = elem_addr_i[s_q.idx * 16 +: 16];
            end
            else if (ack)
            begin
               s_d.elem_val[s_q.idx] = host_rdata_i;
               if (s_q.idx == 5'(NUM_ELEM - 1))
               begin
                  s_d.st  = ST_EVENT;
                  s_d.idx = 5'h00;
               end
               else
                  s_d.idx = s_q.idx + 5'h01;
            end
         end
         ST_EVENT:
         begin
            if (!s_q.ev_hold)
            begin
               s_d.st  = ST_IDLE;
               s_d.cnt = 16'(POLL_CYC - 1);
            end
            else if (!s_q.req_valid)
            begin
               s_d.req_valid = 1'b1;
               s_d.req_write = 1'b1;
               s_d.req_addr  = s_q.ev_addr + {11'h000, s_q.idx};
               s_d.req_wdata = s_q.ev_data[s_q.idx[3:0]];
            end
            else if (ack)
            begin
               if (s_q.idx == s_q.ev_len - 5'h01)
               begin
                  s_d.ev_hold = 1'b0;
                  if (s_q.ev_numeral)
                  begin
                     s_d.num_table = s_q.ev_table;
                     num_word_set  = 1'b1;
                     num_stb_set   = 1'b1;
                  end
                  s_d.st  = ST_IDLE;
                  s_d.cnt = 16'(POLL_CYC - 1);
               end
               else
                  s_d.idx = s_q.idx + 5'h01;
            end
         end
         default:
         begin
            s_d.st        = ST_IDLE;
            s_d.req_valid = 1'b0;
         end
      endcase
      // a table or touch change is taken only while no earlier one is held
      if (ev_valid_i && !s_q.ev_hold)
      begin
         if (ev_len_i == 5'h00 || ev_len_i > ev_limit)
            s_d.ev_reject = 1'b1;
         else
         begin
            s_d.ev_hold    = 1'b1;
            s_d.ev_addr    = ev_addr_i;
            s_d.ev_len     = ev_len_i;
            s_d.ev_numeral = ev_numeral_i;
            s_d.ev_table   = ev_table_i;
            s_d.ev_data    = ev_data_i;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign elem_value_o   = s_q.elem_val;
   assign ev_busy_o      = s_q.ev_hold;
   assign ev_reject_o    = s_q.ev_reject;
   assign req_valid_o    = s_q.req_valid;
   assign req_write_o    = s_q.req_write;
   assign req_addr_o     = s_q.req_addr;
   assign req_wdata_o    = s_q.req_wdata;
   assign screen_o       = s_q.screen;
   assign buzzer_o       = s_q.buzzer;
   assign backlight_o    = s_q.backlight;
   assign priority_reg_o = s_q.prio;
   assign copy_req_o     = s_q.copy_req;
   assign copy_src_o     = s_q.copy_src;
   assign copy_dst_o     = s_q.copy_dst;
   assign copy_type_o    = s_q.copy_type;
endmodule
`default_nettype wire

// file: testbench/ots_host_model.sv
// behavioural host controller word memory answering one word request at a time
// assumes the terminal holds each request until its one-cycle acknowledge
`timescale 1ns/1ns
`default_nettype none
module ots_host_model
(
   input  wire logic        ref_clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        req_valid_i,
   input  wire logic        req_write_i,
   input  wire logic [15:0] req_addr_i,
   input  wire logic [15:0] req_wdata_i,
   input  wire logic [1:0]  delay_i,
   output var  logic        host_ack_o,
   output var  logic [15:0] host_rdata_o
);
   logic [15:0] mem [0:255];
   logic [1:0]  wait_q;

   initial
   begin
      for (int i = 0; i < 256; i++)
         mem[i] = 16'h0000;
   end

   // read data outside an answer toggles so stale values never look valid
   always @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         host_ack_o   <= 1'b0;
         host_rdata_o <= 16'h5a5a;
         wait_q       <= 2'h0;
      end
      else
      begin
         host_ack_o   <= 1'b0;
         host_rdata_o <= ~host_rdata_o;
         if (!req_valid_i || host_ack_o)
            wait_q <= 2'h0;
         else if (wait_q != delay_i)
            wait_q <= wait_q + 2'h1;
         else
         begin
            host_ack_o   <= 1'b1;
            host_rdata_o <= mem[req_addr_i[7:0]];
            if (req_write_i)
               mem[req_addr_i[7:0]] <= req_wdata_i;
         end
      end
   end
endmodule
`default_nettype wire

// file: testbench/ots_checker.sv
// port-level assertions for the terminal status word exchange
// assumes binding onto ots_exchange with a single clock domain
`timescale 1ns/1ns
`default_nettype none
module ots_checker
(
   input wire logic        ref_clk_i,
   input wire logic        rst_b_i,
   input wire logic [15:0] ctl_base_i,
   input wire logic [15:0] ntf_base_i,
   input wire logic        one_to_many_i,
   input wire logic        ev_valid_i,
   input wire logic [4:0]  ev_len_i,
   input wire logic        ev_numeral_i,
   input wire logic        ev_busy_o,
   input wire logic        ev_reject_o,
   input wire logic        req_valid_o,
   input wire logic        req_write_o,
   input wire logic [15:0] req_addr_o,
   input wire logic [15:0] req_wdata_o,
   input wire logic        host_ack_i,
   input wire logic [15:0] screen_o,
   input wire logic        priority_reg_o
);
   import ots_pkg::*;
   logic [4:0] lim;
   assign lim = ev_numeral_i ? NUM_WORDS_MAX : STR_WORDS_MAX;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);

   sequence s_ctl0_ack;
      req_valid_o && !req_write_o && req_addr_o == ctl_base_i && host_ack_i;
   endsequence
   sequence s_ctl1_req;
      req_valid_o && !req_write_o && req_addr_o == ctl_base_i + 16'h1;
   endsequence
   sequence s_scr_write;
      req_valid_o && req_write_o && req_addr_o == ntf_base_i && req_wdata_o == screen_o;
   endsequence

   property p_hold;
      req_valid_o && !host_ack_i |=> req_valid_o && $stable(req_addr_o) && $stable(req_write_o)
         && $stable(req_wdata_o);
   endproperty
   property p_drop; req_valid_o && host_ack_i |=> !req_valid_o; endproperty
   property p_ctl_order; s_ctl0_ack |=> !req_valid_o ##[1:3] s_ctl1_req; endproperty
   property p_prio; $rose(priority_reg_o) |-> one_to_many_i && $past(one_to_many_i); endproperty
   property p_stat;
      req_valid_o && req_write_o && req_addr_o == ntf_base_i + 16'h2
         |-> req_wdata_o[11:0] == 12'h000 && req_wdata_o[NTF_PRIO_BIT] == priority_reg_o;
   endproperty
   property p_scr_note; $changed(screen_o) |-> ##[1:300] s_scr_write; endproperty
   property p_nonzero; $changed(screen_o) |-> screen_o != SCREEN_CLEAR; endproperty
   property p_reject;
      ev_valid_i && !ev_busy_o && (ev_len_i == 5'h00 || ev_len_i > lim) |=> ev_reject_o && !ev_busy_o;
   endproperty
   property p_accept;
      ev_valid_i && !ev_busy_o && ev_len_i != 5'h00 && ev_len_i <= lim |=> ev_busy_o && !ev_reject_o;
   endproperty

   a_hold: assert property (p_hold) else $error("request changed before ack");
   a_drop: assert property (p_drop) else $error("request kept after ack");
   a_ctl_order: assert property (p_ctl_order) else $error("control words out of order");
   a_prio: assert property (p_prio) else $error("priority outside one-to-many");
   a_stat: assert property (p_stat) else $error("status word bits wrong");
   a_scr_note: assert property (p_scr_note) else $error("screen not notified");
   a_nonzero: assert property (p_nonzero) else $error("switched to zero screen");
   a_reject: assert property (p_reject) else $error("bad length accepted");
   a_accept: assert property (p_accept) else $error("good length refused");
endmodule

bind ots_exchange ots_checker i_chk
(
   .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .ctl_base_i(ctl_base_i), .ntf_base_i(ntf_base_i),
   .one_to_many_i(one_to_many_i), .ev_valid_i(ev_valid_i), .ev_len_i(ev_len_i),
   .ev_numeral_i(ev_numeral_i), .ev_busy_o(ev_busy_o), .ev_reject_o(ev_reject_o),
   .req_valid_o(req_valid_o), .req_write_o(req_write_o), .req_addr_o(req_addr_o),
   .req_wdata_o(req_wdata_o), .host_ack_i(host_ack_i), .screen_o(screen_o),
   .priority_reg_o(priority_reg_o)
);
`default_nettype wire

// file: testbench/terminal_status_word_exchange_test.sv
// self-checking bench for ots_exchange against the host word memory model
// assumes the package, design, host model and checker are compiled first
`timescale 1ns/1ns
`default_nettype none
module terminal_status_word_exchange_test;
   import ots_pkg::*;
   localparam logic [15:0] CTL = 16'h0010;
   localparam logic [15:0] NTF = 16'h0020;
   logic         ref_clk, rst_b, otm, op_st, ev_valid, ev_num, ev_busy, ev_rej;
   logic         rv, rw, ack, buzz, blight, prio, cp_req;
   logic [1:0]   dly;
   logic [3:0]   cp_type, type_q;
   logic [4:0]   ev_len;
   logic [11:0]  ev_tab, cp_src, cp_dst, src_q, dst_q;
   logic [15:0]  ev_addr, raddr, wdata, rdata, screen, stat_w;
   logic [63:0]  elem_val;
   logic [255:0] ev_data;
   int           n_fail, checks, n_stat, n_scr, n_num, cyc;

   ots_exchange i_dut
   (
      .ref_clk_i(ref_clk), .rst_b_i(rst_b), .ctl_base_i(CTL), .ntf_base_i(NTF),
      .one_to_many_i(otm), .op_status_i(op_st), .elem_addr_i(64'h0033_0032_0031_0030),
      .elem_value_o(elem_val), .ev_valid_i(ev_valid), .ev_addr_i(ev_addr), .ev_len_i(ev_len),
      .ev_numeral_i(ev_num), .ev_table_i(ev_tab), .ev_data_i(ev_data), .ev_busy_o(ev_busy),
      .ev_reject_o(ev_rej), .req_valid_o(rv), .req_write_o(rw), .req_addr_o(raddr),
      .req_wdata_o(wdata), .host_ack_i(ack), .host_rdata_i(rdata), .screen_o(screen),
      .buzzer_o(buzz), .backlight_o(blight), .priority_reg_o(prio), .copy_req_o(cp_req),
      .copy_src_o(cp_src), .copy_dst_o(cp_dst), .copy_type_o(cp_type)
   );
   ots_host_model i_host
   (
      .ref_clk_i(ref_clk), .rst_b_i(rst_b), .req_valid_i(rv), .req_write_i(rw), .req_addr_i(raddr),
      .req_wdata_i(wdata), .delay_i(dly), .host_ack_o(ack), .host_rdata_o(rdata)
   );

   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic finish_test();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // copy pulses and acked status writes are recorded as they happen
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cp_req)
      begin
         src_q = cp_src;
         dst_q = cp_dst;
         type_q = cp_type;
      end
      if (rv && ack && rw && raddr == NTF + 16'h2)
      begin
         n_stat++;
         stat_w = wdata;
         n_scr += wdata[NTF_SCR_STB_BIT];
         n_num += wdata[NTF_NUM_STB_BIT];
      end
      if (cyc == 20000)
      begin
         n_fail++;
         finish_test();
      end
   end

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wait_stat(input int n);
      int t;
      t = n_stat + n;
      for (int i = 0; i < 2000 && n_stat < t; i++)
         @(negedge ref_clk);
      chk("status writes", 16'h1, 16'(n_stat >= t));
   endtask

   task automatic poke(input logic [15:0] a, input logic [15:0] v);
      @(posedge ref_clk);
      i_host.mem[a[7:0]] <= v;
   endtask

   task automatic ev_send(input logic [15:0] a, input logic [4:0] len, input logic num);
      @(posedge ref_clk);
      ev_valid <= 1'b1;
      ev_addr <= a;
      ev_len <= len;
      ev_num <= num;
      ev_tab <= num ? 12'h345 : 12'h777;
      @(posedge ref_clk);
      ev_valid <= 1'b0;
      @(negedge ref_clk);
   endtask

   task automatic wait_idle();
      for (int i = 0; i < 2000 && ev_busy; i++)
         @(negedge ref_clk);
   endtask

   task automatic t_boot();
      for (int i = 0; i < 20 && !rv; i++)
         @(negedge ref_clk);
      chk("first address", CTL, raddr);
      chk("first is read", 16'h0, 16'(rw));
   endtask

   task automatic t_screen();
      poke(CTL, 16'h0937);
      wait_stat(3);
      chk("screen", 16'h0937, screen);
      chk("notified screen", 16'h0937, i_host.mem[NTF[7:0]]);
      chk("screen strobes", 16'h1, 16'(n_scr));
      chk("strobe cleared", 16'h0, 16'(stat_w[NTF_SCR_STB_BIT]));
      poke(CTL, SCREEN_CLEAR);
      wait_stat(2);
      chk("screen kept", 16'h0937, screen);
      poke(CTL, 16'h0937);
      wait_stat(3);
      chk("screen strobes", 16'h2, 16'(n_scr));
   endtask

   task automatic t_bits();
      poke(CTL + 16'h3, 16'he000);
      op_st <= 1'b1;
      wait_stat(2);
      chk("buzzer", 16'h1, 16'(buzz));
      chk("backlight", 16'h1, 16'(blight));
      chk("priority", 16'h0, 16'(prio));
      chk("status word", 16'h8000, stat_w);
      @(posedge ref_clk);
      otm <= 1'b1;
      wait_stat(2);
      chk("priority", 16'h1, 16'(prio));
      chk("status word", 16'h9000, stat_w);
      poke(CTL + 16'h3, 16'h0000);
      otm <= 1'b0;
      wait_stat(2);
      chk("buzzer", 16'h0, 16'(buzz));
      chk("backlight", 16'h0, 16'(blight));
   endtask

   task automatic t_copy();
      for (int ty = 0; ty < 2; ty++)
      begin
         poke(CTL + 16'h1, 16'h0120 + 16'(ty));
         poke(CTL + 16'h2, {4'(ty), 12'h456});
         wait_stat(3);
         chk("copy source", 16'h0120 + 16'(ty), {4'h0, src_q});
         chk("copy dest", 16'h0456, {4'h0, dst_q});
         chk("copy type", 16'(ty), {12'h0, type_q});
      end
   endtask

   task automatic t_elem();
      @(posedge ref_clk);
      dly <= 2'h2;
      for (int k = 0; k < 4; k++)
         poke(16'h0030 + 16'(k), 16'ha5a0 + 16'(k));
      wait_stat(3);
      for (int k = 0; k < 4; k++)
         chk("element", 16'ha5a0 + 16'(k), elem_val[16*k +: 16]);
      @(posedge ref_clk);
      dly <= 2'h0;
   endtask

   task automatic t_event();
      ev_send(16'h0040, 5'h02, 1'b1);
      chk("busy", 16'h1, 16'(ev_busy));
      wait_idle();
      chk("event word", 16'hb001, i_host.mem[8'h41]);
      wait_stat(3);
      chk("table notify", 16'h0345, i_host.mem[8'h21]);
      chk("numeral strobes", 16'h1, 16'(n_num));
      ev_send(16'h0050, 5'h10, 1'b0);
      wait_idle();
      chk("event word", 16'hb00f, i_host.mem[8'h5f]);
      wait_stat(3);
      chk("table notify", 16'h0345, i_host.mem[8'h21]);
      chk("numeral strobes", 16'h1, 16'(n_num));
      for (int k = 0; k < 3; k++)
      begin
         ev_send(16'h0060, k == 1 ? 5'h11 : 5'(3 * k), k != 1);
         chk("reject", 16'h1, 16'(ev_rej));
         chk("busy", 16'h0, 16'(ev_busy));
      end
   endtask

   initial
   begin
      rst_b = 1'b0;
      otm = 1'b0;
      op_st = 1'b0;
      dly = 2'h0;
      ev_valid = 1'b0;
      ev_num = 1'b0;
      ev_len = 5'h00;
      ev_tab = 12'h000;
      ev_addr = 16'h0000;
      for (int k = 0; k < 16; k++)
         ev_data[16*k +: 16] = 16'hb000 + 16'(k);
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      t_boot();
      t_screen();
      t_bits();
      t_copy();
      t_elem();
      t_event();
      finish_test();
   end
endmodule
`default_nettype wire
